// >>> hw/trace_message_encoder.sv
// Overview of operation
// - transfer code first, then packets in order
// - status, owner, error messages on trace port
// - direct branch: code 3, instruction count
// - code 57: count then unique target address
// - code 4: event id, count, unique address
// - code 9: count then full program counter
// - code 11: count then full address
// - code 12: event id, count, full address
// - code 27: resource code then resource data
// - code 33: event code then count
// - code 5: size, unique address, data
// - code 6: same packets as data write
// - codes 13/14: size, full address, data
// - code 58: type, bit, unique address
// - code 59: type, bit, full address
// - watch hit code 15, trace hit 56
// - reserved codes never sent, dropped instead
// - variable packets lose leading zeros; tool extends
// - every packet ends on port boundary
module trace_message_encoder #(
    parameter int PORT_W = trace_msg_pkg::PORT_W_DEF
) (
    input  wire logic                               clk_i,         // core clock
    input  wire logic                               srst_i,        // sync reset, high
    input  wire logic                               msg_valid_i,   // event request
    output logic                                    msg_ready_o,   // encoder idle
    input  wire logic [trace_msg_pkg::CODE_W-1:0]   msg_code_i,    // transfer code
    input  wire logic [trace_msg_pkg::WORD_W-1:0]   pkt1_i,        // first packet value
    input  wire logic [trace_msg_pkg::WORD_W-1:0]   pkt2_i,        // second packet value
    input  wire logic [trace_msg_pkg::WORD_W-1:0]   pkt3_i,        // third packet value
    output logic [PORT_W-1:0]                       trace_data_o,  // trace port beat
    output logic                                    trace_valid_o, // beat valid
    output logic                                    msg_start_o,   // first beat of message
    output logic                                    pkt_end_o,     // last beat of packet
    output logic                                    msg_end_o,     // last beat of message
    output logic                                    drop_o         // reserved code dropped
);
    import trace_msg_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // message formats

    function automatic logic is_reserved(input logic [5:0] c);
        logic r;
        r = 1'b1;
        unique case (c)
            TC_DEBUG_STATUS, TC_PROCESS_OWNER, TC_DIRECT_BRANCH, TC_INDIRECT_BR,
            TC_DATA_WRITE, TC_DATA_READ, TC_ERROR, TC_FLOW_SYNC, TC_DIRECT_SYNC,
            TC_INDIRECT_SYNC, TC_WRITE_SYNC, TC_READ_SYNC, TC_WATCH_HIT, TC_RES_FULL,
            TC_FLOW_CORR, TC_TRACE_WATCH, TC_BRANCH_TARGET, TC_RMW_ACCESS,
            TC_RMW_SYNC: r = 1'b0;
            // vendor extension has no defined layout here, so it is refused too
            default: r = 1'b1;
        endcase
        return r;
    endfunction : is_reserved

    // packed as {w3,v3,w2,v2,w1,v1}; v = variable length, w = 0 means slot unused
    function automatic logic [20:0] fmt(input logic [5:0] c);
        logic [20:0] f;
        f = '0;
        unique case (c)
            TC_DEBUG_STATUS, TC_PROCESS_OWNER:
                f = {W_NONE, 1'b0, W_NONE, 1'b0, W_WORD, 1'b1};
            TC_ERROR:         f = {W_NONE, 1'b0, W_NONE, 1'b0, W_ERROR_CODE, 1'b0};
            TC_DIRECT_BRANCH: f = {W_NONE, 1'b0, W_NONE, 1'b0, W_ICNT, 1'b1};
            TC_BRANCH_TARGET: f = {W_NONE, 1'b0, W_WORD, 1'b1, W_ICNT, 1'b1};
            TC_INDIRECT_BR:   f = {W_WORD, 1'b1, W_ICNT, 1'b1, W_EVTID, 1'b0};
            TC_FLOW_SYNC:     f = {W_NONE, 1'b0, W_WORD, 1'b1, W_ICNT, 1'b1};
            TC_DIRECT_SYNC:   f = {W_NONE, 1'b0, W_WORD, 1'b1, W_ICNT, 1'b1};
            TC_INDIRECT_SYNC: f = {W_WORD, 1'b1, W_ICNT, 1'b1, W_EVTID, 1'b0};
            TC_RES_FULL:      f = {W_NONE, 1'b0, W_RDATA, 1'b0, W_NIBBLE, 1'b0};
            TC_FLOW_CORR:     f = {W_NONE, 1'b0, W_ICNT, 1'b1, W_NIBBLE, 1'b0};
            TC_DATA_WRITE:    f = {W_WORD, 1'b1, W_WORD, 1'b1, W_SIZE, 1'b0};
            TC_DATA_READ:     f = {W_WORD, 1'b1, W_WORD, 1'b1, W_SIZE, 1'b0};
            TC_WRITE_SYNC, TC_READ_SYNC:
                f = {W_WORD, 1'b1, W_WORD, 1'b1, W_SIZE, 1'b0};
            TC_RMW_ACCESS:    f = {W_WORD, 1'b1, W_BITPOS, 1'b0, W_TYPE, 1'b0};
            TC_RMW_SYNC:      f = {W_WORD, 1'b1, W_BITPOS, 1'b0, W_TYPE, 1'b0};
            TC_WATCH_HIT:     f = {W_NONE, 1'b0, W_NONE, 1'b0, W_HIT_FIELD, 1'b0};
            TC_TRACE_WATCH:   f = {W_NONE, 1'b0, W_NONE, 1'b0, W_TWPHIT, 1'b0};
            default:          f = '0;
        endcase
        return f;
    endfunction : fmt

    function automatic logic [31:0] mask_to(input logic [31:0] v, input logic [5:0] w);
        logic [31:0] m;
        m = '0;
        for (int i = 0; i < WORD_W; i++) begin
            if (i < int'(w)) begin
                m[i] = 1'b1;
            end
        end
        return v & m;
    endfunction : mask_to

    // beats needed; variable packets send only their significant bits
    function automatic logic [5:0] beats_of(input logic [31:0] v, input logic [5:0] w,
                                            input logic var_len);
        int sig;
        sig = int'(w);
        if (var_len) begin
            sig = 1;
            for (int i = 0; i < WORD_W; i++) begin
                if (v[i]) begin
                    sig = i + 1;
                end
            end
        end
        // round up so the packet ends on a port boundary
        return 6'((sig + PORT_W - 1) / PORT_W);
    endfunction : beats_of

    ////////////////////////////////////////////////////////////////////////////
    // state

    enc_state_t             state_ff, nxt_state;
    logic [WORD_W-1:0]      pkt_ff   [NUM_SLOTS];
    logic [WORD_W-1:0]      nxt_pkt  [NUM_SLOTS];
    logic [WID_W-1:0]       wid_ff   [NUM_SLOTS];
    logic [WID_W-1:0]       nxt_wid  [NUM_SLOTS];
    logic [NUM_SLOTS-1:0]   var_ff, nxt_var;
    logic [2:0]             npkt_ff, nxt_npkt;
    logic [1:0]             pidx_ff, nxt_pidx;
    logic [BEAT_W-1:0]      beat_ff, nxt_beat;
    logic [CODE_W-1:0]      code_ff, nxt_code;
    logic [PORT_W-1:0]      data_ff, nxt_data;
    logic                   valid_ff, nxt_valid;
    logic                   start_ff, nxt_start;
    logic                   pend_ff, nxt_pend;
    logic                   mend_ff, nxt_mend;
    logic                   drop_ff, nxt_drop;
    logic                   ready_ff, nxt_ready;
    logic                   accept;
    logic [20:0]            f;
    logic [BEAT_W-1:0]      nbeats;
    logic [SHIFT_W-1:0]     shamt;
    logic [WORD_W-1:0]      shifted;

    assign accept  = msg_valid_i && ready_ff;
    assign f       = fmt(msg_code_i);
    assign nbeats  = beats_of(pkt_ff[pidx_ff], wid_ff[pidx_ff], var_ff[pidx_ff]);
    assign shamt   = SHIFT_W'(beat_ff) * SHIFT_W'(PORT_W);
    assign shifted = pkt_ff[pidx_ff] >> shamt; // least significant beat first

    always_comb begin
        nxt_state = state_ff;
        nxt_pkt   = pkt_ff;
        nxt_wid   = wid_ff;
        nxt_var   = var_ff;
        nxt_npkt  = npkt_ff;
        nxt_pidx  = pidx_ff;
        nxt_beat  = beat_ff;
        nxt_code  = code_ff;
        nxt_data  = '0;
        nxt_valid = 1'b0;
        nxt_start = 1'b0;
        nxt_pend  = 1'b0;
        nxt_mend  = 1'b0;
        nxt_drop  = 1'b0;
        unique case (state_ff)
            ST_IDLE: begin
                if (accept && is_reserved(msg_code_i)) begin
                    nxt_drop = 1'b1;
                end else if (accept) begin
                    nxt_code   = msg_code_i;
                    nxt_pkt[0] = WORD_W'(msg_code_i);
                    nxt_wid[0] = W_CODE;
                    nxt_var[0] = 1'b0;
                    nxt_pkt[1] = mask_to(pkt1_i, f[6:1]);
                    nxt_wid[1] = f[6:1];
                    nxt_var[1] = f[0];
                    nxt_pkt[2] = mask_to(pkt2_i, f[13:8]);
                    nxt_wid[2] = f[13:8];
                    nxt_var[2] = f[7];
                    nxt_pkt[3] = mask_to(pkt3_i, f[20:15]);
                    nxt_wid[3] = f[20:15];
                    nxt_var[3] = f[14];
                    // count only slots the format uses
                    nxt_npkt = 3'd1 + ((f[6:1] != W_NONE) ? 3'd1 : 3'd0)
                             + ((f[13:8] != W_NONE) ? 3'd1 : 3'd0)
                             + ((f[20:15] != W_NONE) ? 3'd1 : 3'd0);
                    nxt_pidx  = '0;
                    nxt_beat  = '0;
                    nxt_state = ST_SEND;
                end
            end
            ST_SEND: begin
                nxt_data  = shifted[PORT_W-1:0];
                nxt_valid = 1'b1;
                nxt_start = (pidx_ff == 2'd0) && (beat_ff == '0);
                if (beat_ff == nbeats - 6'd1) begin
                    nxt_pend = 1'b1;
                    nxt_beat = '0;
                    if ({1'b0, pidx_ff} == npkt_ff - 3'd1) begin
                        nxt_mend  = 1'b1;
                        nxt_state = ST_IDLE;
                    end else begin
                        nxt_pidx = pidx_ff + 2'd1;
                    end
                end else begin
                    nxt_beat = beat_ff + 6'd1;
                end
            end
            default: nxt_state = ST_IDLE;
        endcase
        nxt_ready = (nxt_state == ST_IDLE);
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            state_ff <= ST_IDLE;
            pkt_ff   <= '{default: '0};
            wid_ff   <= '{default: '0};
            var_ff   <= '0;
            npkt_ff  <= '0;
            pidx_ff  <= '0;
            beat_ff  <= '0;
            code_ff  <= '0;
            data_ff  <= '0;
            valid_ff <= 1'b0;
            start_ff <= 1'b0;
            pend_ff  <= 1'b0;
            mend_ff  <= 1'b0;
            drop_ff  <= 1'b0;
            ready_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            pkt_ff   <= nxt_pkt;
            wid_ff   <= nxt_wid;
            var_ff   <= nxt_var;
            npkt_ff  <= nxt_npkt;
            pidx_ff  <= nxt_pidx;
            beat_ff  <= nxt_beat;
            code_ff  <= nxt_code;
            data_ff  <= nxt_data;
            valid_ff <= nxt_valid;
            start_ff <= nxt_start;
            pend_ff  <= nxt_pend;
            mend_ff  <= nxt_mend;
            drop_ff  <= nxt_drop;
            ready_ff <= nxt_ready;
        end
    end

    assign msg_ready_o   = ready_ff;
    assign trace_data_o  = data_ff;
    assign trace_valid_o = valid_ff;
    assign msg_start_o   = start_ff;
    assign pkt_end_o     = pend_ff;
    assign msg_end_o     = mend_ff;
    assign drop_o        = drop_ff;

    ////////////////////////////////////////////////////////////////////////////
    // checks

    logic [2:0] pkt_cnt_ff;
    always_ff @(posedge clk_i) begin
        if (srst_i || mend_ff) begin
            pkt_cnt_ff <= '0;
        end else if (pend_ff) begin
            pkt_cnt_ff <= pkt_cnt_ff + 3'd1;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (srst_i);

    a_code_first: assert property (
        start_ff |-> valid_ff && (data_ff[CODE_W-1:0] == code_ff)) else $error("code not first");
    a_no_reserved: assert property (
        start_ff |-> !is_reserved(code_ff)) else $error("reserved code sent");
    a_drop_reserved: assert property (
        accept && is_reserved(msg_code_i) |=> drop_ff && !valid_ff && ready_ff)
        else $error("reserved code not dropped");
    a_start_after: assert property (
        accept && !is_reserved(msg_code_i) |=> ##1 start_ff) else $error("no message start");
    a_end_boundary: assert property (
        mend_ff |-> pend_ff && valid_ff) else $error("message ends mid packet");
    a_busy_ready: assert property (
        valid_ff && !mend_ff |-> !ready_ff ##1 valid_ff) else $error("message interleaved");
    a_slot_count: assert property (
        mend_ff |-> (pkt_cnt_ff + 3'd1 == npkt_ff)) else $error("wrong packet count");
    // the code beat is a packet of its own, so it carries pkt_end as well
    a_branch_len: assert property (
        accept && msg_code_i == TC_DIRECT_BRANCH && PORT_W >= 8
        |=> ##1 start_ff && pend_ff && !mend_ff ##1 pend_ff && mend_ff)
        else $error("direct branch length");
    a_ready_return: assert property (
        mend_ff |-> ready_ff) else $error("ready late after message");
    a_msg_gap: assert property (
        mend_ff |=> !valid_ff) else $error("messages not separated");

    c_indirect: cover property (accept && msg_code_i == TC_INDIRECT_BR ##[1:40] mend_ff);
    c_dropped: cover property (drop_ff);
    c_back2back: cover property (mend_ff && accept);
    c_data_write: cover property (accept && msg_code_i == TC_DATA_WRITE ##[1:40] mend_ff);
    c_rmw_sync: cover property (accept && msg_code_i == TC_RMW_SYNC ##[1:40] mend_ff);
endmodule : trace_message_encoder

// >>> hw/trace_msg_pkg.sv
package trace_msg_pkg;
    localparam int          CODE_W     = 6;
    localparam int          WORD_W     = 32;
    localparam int          NUM_SLOTS  = 4;   // transfer code plus up to three packets
    localparam int          PORT_W_DEF = 8;
    localparam int          WID_W      = 6;
    localparam int          BEAT_W     = 6;
    localparam int          SHIFT_W    = 12;

    // transfer codes
    localparam logic [5:0] TC_DEBUG_STATUS  = 6'h00;
    localparam logic [5:0] TC_PROCESS_OWNER = 6'h02;
    localparam logic [5:0] TC_DIRECT_BRANCH = 6'h03;
    localparam logic [5:0] TC_INDIRECT_BR   = 6'h04;
    localparam logic [5:0] TC_DATA_WRITE    = 6'h05;
    localparam logic [5:0] TC_DATA_READ     = 6'h06;
    localparam logic [5:0] TC_ERROR         = 6'h08;
    localparam logic [5:0] TC_FLOW_SYNC     = 6'h09;
    localparam logic [5:0] TC_DIRECT_SYNC   = 6'h0B;
    localparam logic [5:0] TC_INDIRECT_SYNC = 6'h0C;
    localparam logic [5:0] TC_WRITE_SYNC    = 6'h0D;
    localparam logic [5:0] TC_READ_SYNC     = 6'h0E;
    localparam logic [5:0] TC_WATCH_HIT     = 6'h0F;
    localparam logic [5:0] TC_RES_FULL      = 6'h1B;
    localparam logic [5:0] TC_FLOW_CORR     = 6'h21;
    localparam logic [5:0] TC_TRACE_WATCH   = 6'h38;
    localparam logic [5:0] TC_BRANCH_TARGET = 6'h39;
    localparam logic [5:0] TC_RMW_ACCESS    = 6'h3A;
    localparam logic [5:0] TC_RMW_SYNC      = 6'h3B;
    localparam logic [5:0] TC_VENDOR_EXT    = 6'h3F;

    // packet widths in bits
    localparam logic [5:0] W_CODE   = 6'h06;
    localparam logic [5:0] W_WORD   = 6'h20;
    localparam logic [5:0] W_ICNT   = 6'h08;
    localparam logic [5:0] W_EVTID  = 6'h02;
    localparam logic [5:0] W_ERROR_CODE  = 6'h05;
    localparam logic [5:0] W_NIBBLE = 6'h04;
    localparam logic [5:0] W_RDATA  = 6'h08;
    localparam logic [5:0] W_SIZE   = 6'h02;
    localparam logic [5:0] W_TYPE   = 6'h02;
    localparam logic [5:0] W_BITPOS = 6'h05;
    localparam logic [5:0] W_HIT_FIELD  = 6'h08;
    localparam logic [5:0] W_TWPHIT = 6'h02;
    localparam logic [5:0] W_NONE   = 6'h00;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_SEND = 2'b10
    } enc_state_t;
endpackage : trace_msg_pkg

// >>> tb/tb.sv
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin error_cnt++; \
    $display("MISMATCH t=%0t got %0h exp %0h", $time, (a), (b)); end end

module tb
    import trace_msg_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int PW = 8;
    // layout entries: bit 6 marks a variable packet, low bits give the width
    localparam logic [6:0] F2 = 7'h02, F4 = 7'h04, F5 = 7'h05, F6 = 7'h06, F8 = 7'h08;
    localparam logic [6:0] V8 = 7'h48, V32 = 7'h60;

    logic              clk_i, srst_i, msg_valid_i, msg_ready_o;
    logic [5:0]        msg_code_i;
    logic [31:0]       pkt1_i, pkt2_i, pkt3_i;
    logic [PW-1:0]     trace_data_o;
    logic              trace_valid_o, msg_start_o, pkt_end_o, msg_end_o, drop_o;
    logic              done;
    logic [31:0]       pkt [NUM_SLOTS];
    logic [2:0]        bts [NUM_SLOTS];
    logic [2:0]        npkt;
    logic [31:0]       exp_q [$];
    logic [31:0]       ev [4];
    logic [31:0]       m;
    logic [6:0]        l;
    int                np, n;
    int                error_cnt = 0;
    int                samples_checked = 0;

    trace_message_encoder #(.PORT_W(PW)) u_trace_message_encoder (.clk_i(clk_i),
        .srst_i(srst_i), .msg_valid_i(msg_valid_i), .msg_ready_o(msg_ready_o),
        .msg_code_i(msg_code_i), .pkt1_i(pkt1_i), .pkt2_i(pkt2_i), .pkt3_i(pkt3_i),
        .trace_data_o(trace_data_o), .trace_valid_o(trace_valid_o),
        .msg_start_o(msg_start_o), .pkt_end_o(pkt_end_o), .msg_end_o(msg_end_o),
        .drop_o(drop_o));

    trace_probe #(.PORT_W(PW)) u_trace_probe (.clk_i(clk_i), .srst_i(srst_i),
        .trace_data_i(trace_data_o), .trace_valid_i(trace_valid_o),
        .msg_start_i(msg_start_o), .pkt_end_i(pkt_end_o), .msg_end_i(msg_end_o),
        .done_o(done), .pkt_o(pkt), .beats_o(bts), .npkt_o(npkt));

    function automatic logic [6:0] lay(input logic [5:0] c, input int i);
        logic [6:0] t [4];
        t = '{F6, 7'h00, 7'h00, 7'h00};
        case (c)
            TC_DEBUG_STATUS, TC_PROCESS_OWNER: t[1] = V32;
            TC_ERROR: t[1] = F5;
            TC_DIRECT_BRANCH: t[1] = V8;
            TC_BRANCH_TARGET, TC_FLOW_SYNC, TC_DIRECT_SYNC: begin
                t[1] = V8;
                t[2] = V32;
            end
            TC_INDIRECT_BR, TC_INDIRECT_SYNC: begin
                t[1] = F2;
                t[2] = V8;
                t[3] = V32;
            end
            TC_RES_FULL: begin
                t[1] = F4;
                t[2] = F8;
            end
            TC_FLOW_CORR: begin
                t[1] = F4;
                t[2] = V8;
            end
            TC_DATA_WRITE, TC_DATA_READ, TC_WRITE_SYNC, TC_READ_SYNC: begin
                t[1] = F2;
                t[2] = V32;
                t[3] = V32;
            end
            TC_RMW_ACCESS, TC_RMW_SYNC: begin
                t[1] = F2;
                t[2] = F5;
                t[3] = V32;
            end
            TC_WATCH_HIT: t[1] = F8;
            TC_TRACE_WATCH: t[1] = F2;
            default: t[0] = 7'h00;
        endcase
        return t[i];
    endfunction : lay

    function automatic int beats(input logic [6:0] x, input logic [31:0] v);
        int w;
        w = int'(x[5:0]);
        if (x[6]) begin
            w = 1;
            for (int b = 0; b < 32; b++) if (v[b]) w = b + 1;
        end
        return (w + PW - 1) / PW;
    endfunction : beats

    function automatic logic [31:0] rnd();
        return $urandom >> ($urandom % 33);
    endfunction : rnd

    task automatic tally_and_finish();
        $display("errors %0d of %0d checks", error_cnt, samples_checked);
        if (error_cnt == 0 && samples_checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : tally_and_finish

    // request held until taken; next call may follow at once for back-to-back traffic
    task automatic send(input logic [5:0] c, input logic [31:0] a, b, d);
        int k;
        msg_valid_i = 1'b1;
        msg_code_i  = c;
        pkt1_i      = a;
        pkt2_i      = b;
        pkt3_i      = d;
        k = 0;
        while (msg_ready_o !== 1'b1) begin
            @(negedge clk_i);
            k++;
            if (k > 200) begin
                error_cnt++;
                $display("MISMATCH t=%0t ready never returned", $time);
                tally_and_finish();
            end
        end
        @(posedge clk_i);
        if (lay(c, 0) != 7'h00) begin
            exp_q.push_back(32'(c));
            exp_q.push_back(a);
            exp_q.push_back(b);
            exp_q.push_back(d);
        end
        @(negedge clk_i);
        `CHK(drop_o, (lay(c, 0) == 7'h00))
    endtask : send

    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    always @(negedge clk_i) begin
        if (done === 1'b1) begin
            if (exp_q.size() < 4) begin
                `CHK(1'b0, 1'b1)
            end else begin
                for (int i = 0; i < 4; i++) ev[i] = exp_q.pop_front();
                np = 0;
                for (int i = 0; i < 4; i++) begin
                    l = lay(ev[0][5:0], i);
                    if (l != 7'h00) begin
                        m = 32'((64'h1 << l[5:0]) - 64'h1);
                        `CHK(pkt[i], ev[i] & m)
                        `CHK(bts[i], 3'(beats(l, ev[i] & m)))
                        np++;
                    end
                end
                `CHK(npkt, 3'(np))
            end
        end
    end

    initial begin
        srst_i      = 1'b1;
        msg_valid_i = 1'b0;
        msg_code_i  = 6'h00;
        pkt1_i      = 32'h0;
        pkt2_i      = 32'h0;
        pkt3_i      = 32'h0;
        repeat (10) @(posedge clk_i);
        @(negedge clk_i);
        srst_i = 1'b0;
        void'($urandom(32'h54DB1949));
        @(negedge clk_i);
        send(TC_DIRECT_BRANCH, 32'h5, 32'h0, 32'h0);
        send(TC_DATA_WRITE, 32'hFFFFFFFF, 32'hFFFFFFFF, 32'hFFFFFFFF);
        send(TC_INDIRECT_SYNC, 32'h0, 32'h0, 32'h0);
        send(TC_VENDOR_EXT, 32'h1, 32'h2, 32'h3);
        for (int c = 0; c < 64; c++) send(6'(c), rnd(), rnd(), rnd());
        repeat (300) send(6'($urandom), rnd(), rnd(), rnd());
        msg_valid_i = 1'b0;
        n = 0;
        while (exp_q.size() != 0 && n < 500) begin
            @(negedge clk_i);
            n++;
        end
        `CHK(exp_q.size(), 0)
        repeat (5) @(negedge clk_i);
        tally_and_finish();
    end
endmodule : tb

// >>> tb/trace_probe.sv
module trace_probe
    import trace_msg_pkg::*;
#(
    parameter int PORT_W = 8
) (
    input  wire logic                clk_i,               // core clock
    input  wire logic                srst_i,              // sync reset, high
    input  wire logic [PORT_W-1:0]   trace_data_i,        // beat data
    input  wire logic                trace_valid_i,       // beat valid
    input  wire logic                msg_start_i,         // first beat of message
    input  wire logic                pkt_end_i,           // last beat of packet
    input  wire logic                msg_end_i,           // last beat of message
    output logic                     done_o,              // message collected
    output logic [WORD_W-1:0]        pkt_o [NUM_SLOTS],   // rebuilt packets
    output logic [2:0]               beats_o [NUM_SLOTS], // beats per packet
    output logic [2:0]               npkt_o               // packets in message
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [WORD_W-1:0] acc;
    int                nb;
    int                np;

    // listen-only: nothing travels back up the trace port
    always @(posedge clk_i) begin
        done_o <= 1'b0;
        if (srst_i) begin
            acc = '0;
            nb  = 0;
            np  = 0;
        end else if (trace_valid_i) begin
            if (msg_start_i) begin
                acc = '0;
                nb  = 0;
                np  = 0;
            end
            // short packets come back zero extended
            acc = acc | (WORD_W'(trace_data_i) << (PORT_W * nb));
            nb++;
            if (pkt_end_i) begin
                if (np < NUM_SLOTS) begin
                    pkt_o[np]   <= acc;
                    beats_o[np] <= 3'(nb);
                end
                np++;
                acc = '0;
                nb  = 0;
            end
            if (msg_end_i) begin
                npkt_o <= 3'(np);
                done_o <= 1'b1;
            end
        end
    end
endmodule : trace_probe
